// ==== hdl/bsp_pkg.sv ====
// constants, opcodes and state codes of the boundary-scan test port
package bsp_pkg;

   // ==========================================================
   // instruction register
   localparam int         IR_W          = 4;
   localparam logic [3:0] OP_EXTEST     = 4'h0;
   localparam logic [3:0] OP_SAMPLE     = 4'h1;
   localparam logic [3:0] OP_IDCODE     = 4'h2;
   localparam logic [3:0] OP_BYPASS     = 4'hf;
   // low two bits must read 01 when the instruction path is captured
   localparam logic [3:0] IR_CAPT_VAL   = 4'h1;

   // ==========================================================
   // identification register
   localparam int         ID_W          = 32;

   // ==========================================================
   // scan chain geometry: three capture stages per i/o pin cell
   localparam int         IO_CELL_W     = 3;
   localparam int         CELL_IN_POS   = 0;
   localparam int         CELL_OUT_POS  = 1;
   localparam int         CELL_OE_POS   = 2;

   // ==========================================================
   // update buffer
   localparam int         BUF_DEPTH     = 2;

   // ==========================================================
   // test access port states
   typedef enum logic [3:0] {
      TLR     = 4'b0000,
      RTI     = 4'b0001,
      SEL_DR  = 4'b0010,
      CAPT_DR = 4'b0011,
      SHFT_DR = 4'b0100,
      EX1_DR  = 4'b0101,
      PAUS_DR = 4'b0110,
      EX2_DR  = 4'b0111,
      UPD_DR  = 4'b1000,
      SEL_IR  = 4'b1001,
      CAPT_IR = 4'b1010,
      SHFT_IR = 4'b1011,
      EX1_IR  = 4'b1100,
      PAUS_IR = 4'b1101,
      EX2_IR  = 4'b1110,
      UPD_IR  = 4'b1111
   } bsp_tap_t;

endpackage : bsp_pkg

// ==== hdl/bsp_buf_if.sv ====
// valid/ready carrier between the transfer logic and the update buffer
`timescale 1ns/100ps
interface bsp_buf_if #(parameter int W = 8);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;

   modport store (
      input  push_valid, push_data, pop_ready,
      output push_ready, pop_valid, pop_data
   );
   modport user (
      output push_valid, push_data, pop_ready,
      input  push_ready, pop_valid, pop_data
   );
endinterface : bsp_buf_if

// ==== hdl/bsp_buf.sv ====
// two-entry valid/ready buffer for boundary update words
`timescale 1ns/100ps
module bsp_buf #(
   parameter int W     = 8,
   parameter int DEPTH = bsp_pkg::BUF_DEPTH
) (
   // clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst_n,
   // ports
   bsp_buf_if.store   b
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : nxt

   assign b.push_ready = (cnt_q != (PW+1)'(DEPTH));
   assign b.pop_valid  = (cnt_q != '0);
   assign b.pop_data   = mem_q[rd_q];
   assign push         = b.push_valid & b.push_ready;
   assign pop          = b.pop_valid & b.pop_ready;

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= b.push_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   property p_no_overfill;
      @(posedge i_sys_clk) disable iff (!i_rst_n) cnt_q <= (PW+1)'(DEPTH);
   endproperty
   a_no_overfill: assert property (p_no_overfill) else $error("update buffer overfilled"); // R11
endmodule : bsp_buf

// ==== hdl/bsp_tap_top.sv ====
// boundary-scan test access port with pin and macrocell scan chain
// Function
// R1: state machine drives all scan-cell control
// R2: every input and i/o pin has a cell
// R3: port resets itself at power-up, no test reset
// R4: sample/preload, extest, bypass, idcode supported
// R5: same four pins carry in-circuit programming; the code has no programming logic
// R6: disabled port frees the four pins
// R7: chain covers i/o, input and macrocell cells
// R8: cell holds three capture, two update stages
// R9: separate cell kinds for pins and macrocells
// R10: one chain from serial in to out
// R11: capture samples, shifts and loads update stages
// R12: optional pull-ups on mode and data input
// R13: behaviour matches the published scan model
// R14: controller drives mode on rise, reads on fall
// R15: bypass is one bit, cleared at capture
// R16: instruction resets to idcode
`timescale 1ns/100ps
module bsp_tap_top #(
   parameter int          N_IO       = 96,
   parameter int          N_IN       = 4,
   parameter int          N_MC       = 128,
   parameter logic [31:0] IDCODE_VAL = 32'h0000_0001, // arbitrary value
   parameter bit          PULLUP_EN  = 1'b1
) (
   // clocks and reset
   input  wire logic            i_sys_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_tck,
   // test access pins
   input  wire logic            i_tms,
   input  wire logic            i_tdi,
   output logic                 o_tdo,
   output logic                 o_tdo_oe,
   output logic                 o_tms_pu_en,
   output logic                 o_tdi_pu_en,
   // configuration
   input  wire logic            i_port_en,
   // device side of the boundary
   input  wire logic [N_IO-1:0] i_pin_in,
   input  wire logic [N_IO-1:0] i_core_out,
   input  wire logic [N_IO-1:0] i_core_oe,
   input  wire logic [N_IN-1:0] i_ded_in,
   input  wire logic [N_MC-1:0] i_mc_state,
   input  wire logic            i_upd_ready,
   output logic [N_IO-1:0]      o_pin_out,
   output logic [N_IO-1:0]      o_pin_oe,
   output logic [N_MC-1:0]      o_mc_upd,
   output logic                 o_extest
);
   localparam int CH_W   = bsp_pkg::IO_CELL_W * N_IO + N_IN + N_MC;
   localparam int MC_POS = bsp_pkg::IO_CELL_W * N_IO + N_IN;
   localparam int PW     = CH_W + 1;

   // ==========================================================
   // test clock domain
   bsp_pkg::bsp_tap_t           state_q;
   logic [bsp_pkg::IR_W-1:0]    ir_sh_q;
   logic [bsp_pkg::IR_W-1:0]    ir_q;
   logic [CH_W-1:0]             chain_q;
   logic [CH_W-1:0]             upd_q;
   wire  [CH_W-1:0]             cap_live;
   logic [CH_W-1:0]             cap_s1_q;
   logic [CH_W-1:0]             cap_s2_q;
   logic [bsp_pkg::ID_W-1:0]    id_q;
   logic                        byp_q;
   logic                        en_s1_q;
   logic                        en_s2_q;
   logic                        req_tgl_q;
   logic                        ack_s1_q;
   logic                        ack_s2_q;
   logic                        ack_tgl_q;
   logic                        send_pend_q;
   logic [PW-1:0]               xfer_q;
   logic                        tdo_q;
   logic                        tdo_oe_q;
   logic                        pu_tms_q;
   logic                        pu_tdi_q;
   logic                        upd_evt;
   logic                        launch;
   logic                        dr_bit;

   function automatic logic is_bnd(input logic [bsp_pkg::IR_W-1:0] ir);
      is_bnd = (ir == bsp_pkg::OP_EXTEST) || (ir == bsp_pkg::OP_SAMPLE);
   endfunction : is_bnd

   function automatic bsp_pkg::bsp_tap_t tap_nxt(input bsp_pkg::bsp_tap_t s, input logic tms);
      case (s) // R13
         bsp_pkg::TLR:     tap_nxt = tms ? bsp_pkg::TLR     : bsp_pkg::RTI;
         bsp_pkg::RTI:     tap_nxt = tms ? bsp_pkg::SEL_DR  : bsp_pkg::RTI;
         bsp_pkg::SEL_DR:  tap_nxt = tms ? bsp_pkg::SEL_IR  : bsp_pkg::CAPT_DR;
         bsp_pkg::CAPT_DR: tap_nxt = tms ? bsp_pkg::EX1_DR  : bsp_pkg::SHFT_DR;
         bsp_pkg::SHFT_DR: tap_nxt = tms ? bsp_pkg::EX1_DR  : bsp_pkg::SHFT_DR;
         bsp_pkg::EX1_DR:  tap_nxt = tms ? bsp_pkg::UPD_DR  : bsp_pkg::PAUS_DR;
         bsp_pkg::PAUS_DR: tap_nxt = tms ? bsp_pkg::EX2_DR  : bsp_pkg::PAUS_DR;
         bsp_pkg::EX2_DR:  tap_nxt = tms ? bsp_pkg::UPD_DR  : bsp_pkg::SHFT_DR;
         bsp_pkg::UPD_DR:  tap_nxt = tms ? bsp_pkg::SEL_DR  : bsp_pkg::RTI;
         bsp_pkg::SEL_IR:  tap_nxt = tms ? bsp_pkg::TLR     : bsp_pkg::CAPT_IR;
         bsp_pkg::CAPT_IR: tap_nxt = tms ? bsp_pkg::EX1_IR  : bsp_pkg::SHFT_IR;
         bsp_pkg::SHFT_IR: tap_nxt = tms ? bsp_pkg::EX1_IR  : bsp_pkg::SHFT_IR;
         bsp_pkg::EX1_IR:  tap_nxt = tms ? bsp_pkg::UPD_IR  : bsp_pkg::PAUS_IR;
         bsp_pkg::PAUS_IR: tap_nxt = tms ? bsp_pkg::EX2_IR  : bsp_pkg::PAUS_IR;
         bsp_pkg::EX2_IR:  tap_nxt = tms ? bsp_pkg::UPD_IR  : bsp_pkg::SHFT_IR;
         bsp_pkg::UPD_IR:  tap_nxt = tms ? bsp_pkg::SEL_DR  : bsp_pkg::RTI;
         default:          tap_nxt = bsp_pkg::TLR;
      endcase
   endfunction : tap_nxt

   // ==========================================================
   // pin cells and macrocell cells feeding the capture stages
   genvar gi;
   generate
      for (gi = 0; gi < N_IO; gi++) begin : g_io_cell
         assign cap_live[bsp_pkg::IO_CELL_W*gi + bsp_pkg::CELL_IN_POS]  = i_pin_in[gi];   // R2 R9
         assign cap_live[bsp_pkg::IO_CELL_W*gi + bsp_pkg::CELL_OUT_POS] = i_core_out[gi]; // R8
         assign cap_live[bsp_pkg::IO_CELL_W*gi + bsp_pkg::CELL_OE_POS]  = i_core_oe[gi];  // R8
      end
   endgenerate
   assign cap_live[bsp_pkg::IO_CELL_W*N_IO +: N_IN] = i_ded_in;   // R2 R7
   assign cap_live[MC_POS +: N_MC]                  = i_mc_state; // R9 R7

   // live levels come from other domains, so two stages before use
   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_s1_q <= '0;
         cap_s2_q <= '0;
         en_s1_q  <= 1'b0;
         en_s2_q  <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         cap_s1_q <= cap_live;
         cap_s2_q <= cap_s1_q;
         en_s1_q  <= i_port_en;
         en_s2_q  <= en_s1_q;
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // ==========================================================
   // state machine; power-up reset lands in test-logic-reset
   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= bsp_pkg::TLR; // R3
      end else if (!en_s2_q) begin
         state_q <= bsp_pkg::TLR; // R6
      end else begin
         state_q <= tap_nxt(state_q, i_tms); // R1 R14 R5
      end
   end

   // ==========================================================
   // instruction path
   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ir_sh_q <= bsp_pkg::IR_CAPT_VAL;
         ir_q    <= bsp_pkg::OP_IDCODE; // R16
      end else begin
         case (state_q)
            bsp_pkg::TLR:     ir_q    <= bsp_pkg::OP_IDCODE; // R16
            bsp_pkg::CAPT_IR: ir_sh_q <= bsp_pkg::IR_CAPT_VAL;
            bsp_pkg::SHFT_IR: ir_sh_q <= {i_tdi, ir_sh_q[bsp_pkg::IR_W-1:1]};
            bsp_pkg::UPD_IR:  ir_q    <= ir_sh_q; // R4
            default:          ir_q    <= ir_q;
         endcase
      end
   end

   // ==========================================================
   // data paths: boundary chain, identification, bypass
   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chain_q <= '0;
      end else if (is_bnd(ir_q)) begin
         if (state_q == bsp_pkg::CAPT_DR) begin
            chain_q <= cap_s2_q; // R11
         end else if (state_q == bsp_pkg::SHFT_DR) begin
            chain_q <= {i_tdi, chain_q[CH_W-1:1]}; // R10 R11
         end
      end
   end

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         upd_q <= '0;
      end else if (state_q == bsp_pkg::UPD_DR && is_bnd(ir_q)) begin
         upd_q <= chain_q; // R11 R8
      end
   end

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         id_q <= '0;
      end else if (ir_q == bsp_pkg::OP_IDCODE) begin
         if (state_q == bsp_pkg::CAPT_DR) begin
            id_q <= IDCODE_VAL; // R4
         end else if (state_q == bsp_pkg::SHFT_DR) begin
            id_q <= {i_tdi, id_q[bsp_pkg::ID_W-1:1]};
         end
      end
   end

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         byp_q <= 1'b0;
      end else if (state_q == bsp_pkg::CAPT_DR) begin
         byp_q <= 1'b0; // R15
      end else if (state_q == bsp_pkg::SHFT_DR) begin
         byp_q <= i_tdi; // R15
      end
   end

   // ==========================================================
   // serial output changes on the falling edge for the controller
   always_comb begin
      if (is_bnd(ir_q)) begin
         dr_bit = chain_q[0];
      end else if (ir_q == bsp_pkg::OP_IDCODE) begin
         dr_bit = id_q[0];
      end else begin
         dr_bit = byp_q; // unknown opcodes fall back to bypass
      end
   end

   always_ff @(negedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q    <= (state_q == bsp_pkg::SHFT_IR) ? ir_sh_q[0] : dr_bit; // R10 R14
         tdo_oe_q <= en_s2_q && (state_q == bsp_pkg::SHFT_IR ||
                                 state_q == bsp_pkg::SHFT_DR); // R6
      end
   end

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pu_tms_q <= 1'b0;
         pu_tdi_q <= 1'b0;
      end else begin
         pu_tms_q <= PULLUP_EN && en_s2_q; // R12
         pu_tdi_q <= PULLUP_EN && en_s2_q; // R12
      end
   end

   // ==========================================================
   // update word handoff to the system clock domain (toggle + ack)
   assign upd_evt = (state_q == bsp_pkg::UPD_DR && is_bnd(ir_q)) ||
                    (state_q == bsp_pkg::UPD_IR);
   assign launch  = send_pend_q && (ack_s2_q == req_tgl_q);

   always_ff @(posedge i_tck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         send_pend_q <= 1'b0;
         req_tgl_q   <= 1'b0;
         xfer_q      <= '0;
      end else begin
         // a new update in the launch cycle keeps the request pending
         send_pend_q <= upd_evt | (send_pend_q & ~launch);
         if (launch) begin
            req_tgl_q <= ~req_tgl_q;
            xfer_q    <= {ir_q == bsp_pkg::OP_EXTEST, upd_q};
         end
      end
   end

   // ==========================================================
   // system clock domain
   logic          req_s1_q;
   logic          req_s2_q;
   logic          req_s3_q;
   logic          pend_q;
   wire  [N_IO-1:0] pin_out_d;
   wire  [N_IO-1:0] pin_oe_d;
   logic [PW-1:0] data_q;
   logic [PW-1:0] apply_q;
   logic          sen_s1_q;
   logic          sen_s2_q;
   logic          ext;

   bsp_buf_if #(.W(PW)) ub ();

   bsp_buf #(.W(PW), .DEPTH(bsp_pkg::BUF_DEPTH)) u_buf (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .b         (ub.store)
   );

   assign ub.push_valid = pend_q;
   assign ub.push_data  = data_q;
   assign ub.pop_ready  = i_upd_ready;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
         sen_s1_q <= 1'b0;
         sen_s2_q <= 1'b0;
      end else begin
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
         sen_s1_q <= i_port_en;
         sen_s2_q <= sen_s1_q;
      end
   end

   // the ack returns only when the buffer takes the word, so a full buffer holds off the next launch;
   // updates made meanwhile overwrite upd_q and only the latest word is sent
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_q    <= 1'b0;
         ack_tgl_q <= 1'b0;
         data_q    <= '0;
      end else if (req_s2_q != req_s3_q) begin
         pend_q <= 1'b1;
         data_q <= xfer_q;
      end else if (pend_q && ub.push_ready) begin
         pend_q    <= 1'b0;
         ack_tgl_q <= ~ack_tgl_q;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         apply_q <= '0;
      end else if (ub.pop_valid && ub.pop_ready) begin
         apply_q <= ub.pop_data; // R11
      end
   end

   assign ext = apply_q[PW-1] & sen_s2_q;

   generate
      for (gi = 0; gi < N_IO; gi++) begin : g_io_drive
         assign pin_out_d[gi] = ext ? apply_q[bsp_pkg::IO_CELL_W*gi + bsp_pkg::CELL_OUT_POS]
                                    : i_core_out[gi]; // R2 R4
         assign pin_oe_d[gi]  = ext ? apply_q[bsp_pkg::IO_CELL_W*gi + bsp_pkg::CELL_OE_POS]
                                    : i_core_oe[gi];  // R2 R4
      end
   endgenerate

   // one process owns the pin registers, per-bit processes would be multiple drivers
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pin_out <= '0;
         o_pin_oe  <= '0;
      end else begin
         o_pin_out <= pin_out_d;
         o_pin_oe  <= pin_oe_d;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mc_upd <= '0;
         o_extest <= 1'b0;
      end else begin
         o_mc_upd <= apply_q[MC_POS +: N_MC]; // R9
         o_extest <= ext;
      end
   end

   assign o_tdo       = tdo_q;
   assign o_tdo_oe    = tdo_oe_q;
   assign o_tms_pu_en = pu_tms_q;
   assign o_tdi_pu_en = pu_tdi_q;

   // ==========================================================
   // checks
   property p_tms_reset;
      @(posedge i_tck) disable iff (!i_rst_n) i_tms [*5] |=> state_q == bsp_pkg::TLR;
   endproperty
   a_tms_reset: assert property (p_tms_reset) else $error("five tms highs missed reset"); // R1

   property p_ir_default;
      @(posedge i_tck) disable iff (!i_rst_n)
         state_q == bsp_pkg::TLR |=> ir_q == bsp_pkg::OP_IDCODE;
   endproperty
   a_ir_default: assert property (p_ir_default) else $error("ir not idcode after reset"); // R16

   property p_byp_clear;
      @(posedge i_tck) disable iff (!i_rst_n) state_q == bsp_pkg::CAPT_DR |=> !byp_q;
   endproperty
   a_byp_clear: assert property (p_byp_clear) else $error("bypass bit not cleared"); // R15

   property p_chain_shift;
      @(posedge i_tck) disable iff (!i_rst_n)
         state_q == bsp_pkg::SHFT_DR && is_bnd(ir_q) |=> chain_q[CH_W-1] == $past(i_tdi);
   endproperty
   a_chain_shift: assert property (p_chain_shift) else $error("chain did not take tdi"); // R10

   property p_chain_capt;
      @(posedge i_tck) disable iff (!i_rst_n)
         state_q == bsp_pkg::CAPT_DR && is_bnd(ir_q) |=> chain_q == $past(cap_s2_q);
   endproperty
   a_chain_capt: assert property (p_chain_capt) else $error("chain did not capture pins"); // R11

   property p_upd_load;
      @(posedge i_tck) disable iff (!i_rst_n)
         state_q == bsp_pkg::UPD_DR && is_bnd(ir_q) |=> upd_q == $past(chain_q) && send_pend_q;
   endproperty
   a_upd_load: assert property (p_upd_load) else $error("update stages not loaded"); // R8

   property p_disabled;
      @(posedge i_tck) disable iff (!i_rst_n)
         !en_s2_q |=> state_q == bsp_pkg::TLR ##0 !o_tdo_oe;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled port still active"); // R6

   property p_idcode;
      @(posedge i_tck) disable iff (!i_rst_n)
         state_q == bsp_pkg::CAPT_DR && ir_q == bsp_pkg::OP_IDCODE |=> id_q == IDCODE_VAL;
   endproperty
   a_idcode: assert property (p_idcode) else $error("identification value not captured"); // R4

   property p_pullup;
      @(posedge i_tck) disable iff (!i_rst_n)
         $rose(en_s2_q) |=> o_tms_pu_en == PULLUP_EN && o_tdi_pu_en == PULLUP_EN;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up enable wrong"); // R12

   c_extest: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_extest));
   c_buf_hold: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ub.pop_valid && !ub.pop_ready);
   c_bypass: cover property (@(posedge i_tck) disable iff (!i_rst_n)
      state_q == bsp_pkg::SHFT_DR && ir_q == bsp_pkg::OP_BYPASS);
endmodule : bsp_tap_top

// ==== verification/bsp_jtag_ctl.sv ====
// behavioural test controller driving tck, tms and tdi and reading tdo
`timescale 1ns/100ps
module bsp_jtag_ctl (
   // test access pins
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   // ==========================================================
   // pin sequencing
   logic tdo_s;
   logic oe_seen;
   initial begin
      o_tck   = 1'b0;
      o_tms   = 1'b1;
      o_tdi   = 1'b1;
      tdo_s   = 1'b0;
      oe_seen = 1'b0;
   end
   // tck stays low between frames; tdo is read once the falling edge has settled
   task automatic step(input logic tms, input logic tdi);
      o_tms = tms;
      o_tdi = tdi;
      #5 o_tck = 1'b1;
      #6 o_tck = 1'b0;
      #1 tdo_s = i_tdo;
      oe_seen = oe_seen | i_tdo_oe;
   endtask : step
   // five highs reach the reset state from anywhere, then park in idle
   task automatic tlr();
      repeat (5) step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask : tlr
   // one full scan from idle back to idle, bits first in first out
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      dout = '0;
      step(1'b1, 1'b1);
      if (ir) begin
         step(1'b1, 1'b1);
      end
      step(1'b0, 1'b1);
      step(1'b0, 1'b1);
      for (int i = 0; i < n; i++) begin
         dout[i] = tdo_s;
         step(i == n - 1, din[i]);
      end
      // released data line rests at its pull-up level
      step(1'b1, 1'b1);
      repeat (3) step(1'b0, 1'b1);
   endtask : scan
endmodule : bsp_jtag_ctl

// ==== verification/tb_top.sv ====
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module tb_top;
   // ==========================================================
   // environment
   localparam logic [31:0] ID    = 32'h1234_5679; // arbitrary value
   localparam int          WD_NS = 200000;
   logic        sys_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, tms_pu, tdi_pu;
   logic        port_en, upd_ready, extest, ded_in;
   logic [1:0]  pin_in, core_out, core_oe, mc_state, pin_out, pin_oe, mc_upd;
   logic [31:0] d;
   int          num_errors, n_checks;

   always #5 sys_clk = ~sys_clk;

   bsp_tap_top #(.N_IO(2), .N_IN(1), .N_MC(2), .IDCODE_VAL(ID), .PULLUP_EN(1'b1))
   i_bsp_tap_top (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_tms_pu_en(tms_pu),
      .o_tdi_pu_en(tdi_pu), .i_port_en(port_en), .i_pin_in(pin_in),
      .i_core_out(core_out), .i_core_oe(core_oe), .i_ded_in(ded_in),
      .i_mc_state(mc_state), .i_upd_ready(upd_ready), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_mc_upd(mc_upd), .o_extest(extest));

   bsp_jtag_ctl i_bsp_jtag_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
      .i_tdo_oe(tdo_oe));

   // ==========================================================
   // helpers
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic sys_wait(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : sys_wait
   task automatic end_of_test();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // ==========================================================
   // scenarios
   task automatic t_idcode();
      i_bsp_jtag_ctl.oe_seen = 1'b0;
      i_bsp_jtag_ctl.scan(1'b0, 32, 32'h0, d);
      chk("idcode", ID, d);
      chk("tdo_oe", 32'h1, {31'h0, i_bsp_jtag_ctl.oe_seen});
      chk("pullups", 32'h3, {30'h0, tms_pu, tdi_pu});
   endtask : t_idcode
   task automatic t_bypass();
      i_bsp_jtag_ctl.scan(1'b1, 4, {28'h0, bsp_pkg::OP_BYPASS}, d);
      chk("ir_capture", {28'h0, bsp_pkg::IR_CAPT_VAL}, d);
      i_bsp_jtag_ctl.scan(1'b0, 5, 32'h0b, d);
      chk("bypass", 32'h16, d);
   endtask : t_bypass
   task automatic t_sample_extest();
      i_bsp_jtag_ctl.scan(1'b1, 4, {28'h0, bsp_pkg::OP_SAMPLE}, d);
      i_bsp_jtag_ctl.scan(1'b0, 9, 32'h136, d);
      chk("capture", {23'h0, mc_state, ded_in, core_oe[1], core_out[1], pin_in[1],
          core_oe[0], core_out[0], pin_in[0]}, d);
      sys_wait(30);
      chk("pins_normal", {30'h0, core_out}, {30'h0, pin_out});
      upd_ready = 1'b0;
      i_bsp_jtag_ctl.scan(1'b1, 4, {28'h0, bsp_pkg::OP_EXTEST}, d);
      sys_wait(30);
      chk("extest_stalled", 32'h0, {31'h0, extest});
      upd_ready = 1'b1;
      sys_wait(30);
      chk("extest", 32'h1, {31'h0, extest});
      chk("preload", 32'h3e, {26'h0, pin_oe, pin_out, mc_upd});
      i_bsp_jtag_ctl.scan(1'b1, 4, {28'h0, bsp_pkg::OP_BYPASS}, d);
      sys_wait(30);
      chk("extest_off", {29'h0, 1'b0, core_out}, {29'h0, extest, pin_out});
   endtask : t_sample_extest
   task automatic t_disable();
      port_en = 1'b0;
      sys_wait(10);
      i_bsp_jtag_ctl.oe_seen = 1'b0;
      i_bsp_jtag_ctl.scan(1'b0, 4, 32'h5, d);
      chk("tdo_oe_off", 32'h0, {31'h0, i_bsp_jtag_ctl.oe_seen});
      chk("pullups_off", 32'h0, {30'h0, tms_pu, tdi_pu});
      sys_wait(1);
      port_en = 1'b1;
      sys_wait(10);
      i_bsp_jtag_ctl.tlr();
      t_idcode();
   endtask : t_disable

   // ==========================================================
   // main sequence and watchdog
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      port_en = 1'b1;
      upd_ready = 1'b1;
      pin_in = 2'b10;
      core_out = 2'b01;
      core_oe = 2'b11;
      ded_in = 1'b1;
      mc_state = 2'b10;
      num_errors = 0;
      n_checks = 0;
      fork
         sys_wait(6);
         i_bsp_jtag_ctl.tlr();
      join
      sys_wait(1);
      rst_n = 1'b1;
      i_bsp_jtag_ctl.tlr();
      t_idcode();
      t_bypass();
      t_sample_extest();
      t_disable();
      end_of_test();
   end
   initial begin
      #(WD_NS);
      num_errors++;
      end_of_test();
   end
endmodule : tb_top
